// ### hdl/escif_pkg.sv
package escif_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ESCIF_CTRL_OFS = 8'h00;
  localparam logic [7:0] ESCIF_STAT_OFS = 8'h04;
  localparam logic [7:0] ESCIF_TXCNT_OFS = 8'h08;
  localparam logic [7:0] ESCIF_RXCNT_OFS = 8'h0c;
  localparam int ESCIF_CTRL_BUILD_BIT = 0;
  localparam logic ESCIF_CTRL_BUILD_RST = 1'b1;
  localparam logic [31:0] ESCIF_CNT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Stream fields and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ESCIF_FLAG_NORMAL = 4'ha;
  localparam logic [3:0] ESCIF_FLAG_RXSTAT = 4'h5;
  localparam logic [1:0] ESCIF_CSUM_PARTIAL = 2'h1;
  localparam logic [2:0] ESCIF_W_TAG = 3'h0;
  localparam logic [2:0] ESCIF_W_MODE = 3'h1;
  localparam logic [2:0] ESCIF_W_OFS = 3'h2;
  localparam logic [2:0] ESCIF_W_SEED = 3'h3;
  localparam logic [2:0] ESCIF_W_LAST = 3'h5;
  localparam logic [3:0] ESCIF_STRB_FULL = 4'hf;
  localparam logic [15:0] ESCIF_CSUM_ONES = 16'hffff;
  localparam logic [15:0] ESCIF_CSUM_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tvalid;
    logic [31:0] tdata;
    logic [3:0] tstrb;
    logic tlast;
  } escif_axis_t;

  typedef struct packed {
    logic csum_on;
    logic loopback;
    logic [15:0] checksum_start_offset;
    logic [15:0] checksum_insert_offset;
    logic [15:0] checksum_seed;
  } escif_txinfo_t;

  typedef struct packed {
    logic sclk;
    escif_axis_t txc;
    escif_axis_t txd;
    logic rxs_tready;
    logic rxd_tready;
  } escif_pins_t;

  typedef enum logic {ESCIF_TX_CTL, ESCIF_TX_DATA} escif_tx_state_t;
  typedef enum logic {ESCIF_RX_STAT, ESCIF_RX_DATA} escif_rx_state_t;

endpackage : escif_pkg

// ### hdl/escif_core.sv
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module escif_core
  import escif_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite register slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Stream clock pin, shared by all four streams.
  input wire logic rx_status_stream_clock,
  // Transmit control and data streams from the source.
  input wire escif_axis_t txc,
  output logic txc_tready,
  input wire escif_axis_t txd,
  output logic txd_tready,
  // Receive status and data streams to the destination.
  output escif_axis_t rxs,
  input wire logic rx_status_stream_ready,
  output escif_axis_t rxd,
  input wire logic rxd_tready,
  // MAC transmit side.
  output escif_axis_t mac_tx,
  input wire logic mac_tx_tready,
  output escif_txinfo_t tx_info,
  input wire logic [15:0] tx_csum_result,
  input wire logic tx_frame_is_udp,
  output logic [15:0] tx_csum_final,
  // MAC receive side; a word is held until its take pulse.
  input wire escif_axis_t mac_rxs,
  output logic mac_rxs_take,
  input wire escif_axis_t mac_rxd,
  output logic mac_rxd_take
);

  // ----------------------------------------------------------------
  // Pin synchronisers and stream clock edge
  // ----------------------------------------------------------------
  // The control strobes are never looked at, so they may be tied off.
  escif_pins_t pins;
  escif_pins_t sync1;
  escif_pins_t sync2;
  escif_pins_t pre;
  logic sedge;

  assign pins.sclk = rx_status_stream_clock;
  assign pins.txc = txc;
  assign pins.txd = txd;
  assign pins.rxs_tready = rx_status_stream_ready;
  assign pins.rxd_tready = rxd_tready;

  // The stage after the second one holds the pins as they stood just
  // before the stream clock rose, which is what the far end committed to.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      pre <= '0;
    end else if (clk_en) begin
      sync1 <= pins;
      sync2 <= sync1;
      pre <= sync2;
    end
  end

  assign sedge = clk_en && sync2.sclk && !pre.sclk;

  // ----------------------------------------------------------------
  // Transmit control stream
  // ----------------------------------------------------------------
  escif_tx_state_t tx_state;
  escif_tx_state_t next_tx_state;
  logic [2:0] ctl_idx;
  logic [3:0] ctl_flag;
  logic [1:0] ctl_mode;
  logic [31:0] ctl_ofs;
  logic [15:0] ctl_seed;
  logic csum_build;
  wire ctl_take = sedge && txc_tready && pre.txc.tvalid;
  wire ctl_end = ctl_take && pre.txc.tlast;
  wire [3:0] end_flag = (ctl_idx == ESCIF_W_TAG) ?
                        pre.txc.tdata[31:28] : ctl_flag;
  wire flag_normal = (end_flag == ESCIF_FLAG_NORMAL);
  wire flag_rxstat = (end_flag == ESCIF_FLAG_RXSTAT);
  wire ctl_accept = ctl_end && (flag_normal || flag_rxstat);
  wire txd_take = sedge && txd_tready && pre.txd.tvalid;
  wire txd_end = txd_take && pre.txd.tlast;
  wire slot_free = !txd_take && (!mac_tx.tvalid || mac_tx_tready);

  always_comb begin
    next_tx_state = tx_state;
    case (tx_state)
      ESCIF_TX_CTL: begin
        if (ctl_accept) begin
          next_tx_state = ESCIF_TX_DATA;
        end
      end
      ESCIF_TX_DATA: begin
        if (txd_end) begin
          next_tx_state = ESCIF_TX_CTL;
        end
      end
      default: begin
        next_tx_state = ESCIF_TX_CTL;
      end
    endcase
  end

  // The fifth and sixth words are counted but never stored; a seventh wraps to the tag slot.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_idx <= ESCIF_W_TAG;
      ctl_flag <= 4'h0;
      ctl_mode <= 2'h0;
      ctl_ofs <= 32'h0000_0000;
      ctl_seed <= 16'h0000;
    end else if (ctl_take) begin
      ctl_idx <= (ctl_end || ctl_idx == ESCIF_W_LAST) ? ESCIF_W_TAG :
                 ctl_idx + 3'h1;
      case (ctl_idx)
        ESCIF_W_TAG: ctl_flag <= pre.txc.tdata[31:28];
        ESCIF_W_MODE: ctl_mode <= pre.txc.tdata[1:0];
        ESCIF_W_OFS: ctl_ofs <= pre.txc.tdata;
        ESCIF_W_SEED: ctl_seed <= pre.txc.tdata[15:0];
        default: ctl_seed <= ctl_seed;
      endcase
    end
  end

  // Ready lines change only at a stream clock edge so that the far end
  // sees a stable level for the whole stream clock period.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= ESCIF_TX_CTL;
      txc_tready <= 1'b0;
      txd_tready <= 1'b0;
    end else if (sedge) begin
      tx_state <= next_tx_state;
      txc_tready <= (next_tx_state == ESCIF_TX_CTL);
      txd_tready <= (next_tx_state == ESCIF_TX_DATA) && slot_free;
    end
  end

  // A frame whose flag is reserved leaves the stream waiting for
  // the next control packet; its data is never let in.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_info <= '0;
    end else if (ctl_accept) begin
      tx_info.csum_on <= flag_normal && csum_build &&
                         (ctl_mode == ESCIF_CSUM_PARTIAL);
      tx_info.loopback <= flag_rxstat;
      tx_info.checksum_start_offset <= ctl_ofs[31:16];
      tx_info.checksum_insert_offset <= ctl_ofs[15:0];
      tx_info.checksum_seed <= ctl_seed;
    end
  end

  // ----------------------------------------------------------------
  // Transmit data towards the MAC
  // ----------------------------------------------------------------
  // One holding word only: each accepted beat costs one stream period
  // of ready low, traded for no buffer at all.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_tx <= '0;
    end else if (txd_take) begin
      mac_tx.tvalid <= 1'b1;
      mac_tx.tdata <= pre.txd.tdata;
      mac_tx.tlast <= pre.txd.tlast;
      mac_tx.tstrb <= pre.txd.tlast ? pre.txd.tstrb :
                      ESCIF_STRB_FULL;
    end else if (clk_en && mac_tx_tready) begin
      mac_tx.tvalid <= 1'b0;
    end
  end

  wire csum_zero = (tx_csum_result == ESCIF_CSUM_ZERO);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_csum_final <= ESCIF_CSUM_ZERO;
    end else if (clk_en) begin
      tx_csum_final <= (tx_frame_is_udp && csum_zero) ?
                       ESCIF_CSUM_ONES : tx_csum_result;
    end
  end

  // ----------------------------------------------------------------
  // Receive status then data
  // ----------------------------------------------------------------
  escif_rx_state_t rx_state;
  escif_rx_state_t next_rx_state;
  logic rxs_first;
  wire s_acc = sedge && rxs.tvalid && pre.rxs_tready;
  wire s_last_acc = s_acc && rxs.tlast;
  wire d_acc = sedge && rxd.tvalid && pre.rxd_tready;
  wire d_last_acc = d_acc && rxd.tlast;
  wire load_s = sedge && (rx_state == ESCIF_RX_STAT) && !s_last_acc &&
                (!rxs.tvalid || pre.rxs_tready) && mac_rxs.tvalid;
  wire load_d = sedge && (rx_state == ESCIF_RX_DATA) && !d_last_acc &&
                (!rxd.tvalid || pre.rxd_tready) && mac_rxd.tvalid;

  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      ESCIF_RX_STAT: begin
        if (s_last_acc) begin
          next_rx_state = ESCIF_RX_DATA;
        end
      end
      ESCIF_RX_DATA: begin
        if (d_last_acc) begin
          next_rx_state = ESCIF_RX_STAT;
        end
      end
      default: begin
        next_rx_state = ESCIF_RX_STAT;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= ESCIF_RX_STAT;
      rxs_first <= 1'b1;
      mac_rxs_take <= 1'b0;
      mac_rxd_take <= 1'b0;
    end else if (clk_en) begin
      rx_state <= next_rx_state;
      mac_rxs_take <= load_s;
      mac_rxd_take <= load_d;
      if (load_s) begin
        rxs_first <= mac_rxs.tlast;
      end
    end
  end

  // The first status word always leaves with the status flag in place.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxs <= '0;
    end else if (load_s) begin
      rxs.tvalid <= 1'b1;
      rxs.tdata <= rxs_first ? {ESCIF_FLAG_RXSTAT, mac_rxs.tdata[27:0]} :
                   mac_rxs.tdata;
      rxs.tstrb <= ESCIF_STRB_FULL;
      rxs.tlast <= mac_rxs.tlast;
    end else if (s_acc) begin
      rxs.tvalid <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd <= '0;
    end else if (load_d) begin
      rxd.tvalid <= 1'b1;
      rxd.tdata <= mac_rxd.tdata;
      rxd.tstrb <= mac_rxd.tlast ? mac_rxd.tstrb :
                   ESCIF_STRB_FULL;
      rxd.tlast <= mac_rxd.tlast;
    end else if (d_acc) begin
      rxd.tvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite registers
  // ----------------------------------------------------------------
  // Zero wait states; with clk_en low a write is lost, so software must
  // not access the block while it is frozen.
  logic dp_wr;
  logic [7:0] dp_addr;
  logic [31:0] tx_frames;
  logic [31:0] rx_frames;
  logic [31:0] rd_mux;
  wire ap_valid = hsel && htrans[1] && hready;
  wire [7:0] ap_addr = haddr[7:0];
  wire wr_ctrl = clk_en && dp_wr && (dp_addr == ESCIF_CTRL_OFS);
  wire [31:0] stat_word = {28'h0000000, tx_info.csum_on,
                           (rx_state == ESCIF_RX_DATA), tx_info.loopback,
                           (tx_state == ESCIF_TX_DATA)};

  always_comb begin
    case (ap_addr)
      ESCIF_CTRL_OFS: rd_mux = {31'h00000000, csum_build};
      ESCIF_STAT_OFS: rd_mux = stat_word;
      ESCIF_TXCNT_OFS: rd_mux = tx_frames;
      ESCIF_RXCNT_OFS: rd_mux = rx_frames;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      dp_wr <= ap_valid && hwrite;
      dp_addr <= ap_addr;
      if (ap_valid && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csum_build <= ESCIF_CTRL_BUILD_RST;
      tx_frames <= ESCIF_CNT_RST;
      rx_frames <= ESCIF_CNT_RST;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        csum_build <= hwdata[ESCIF_CTRL_BUILD_BIT];
      end
      if (txd_end) begin
        tx_frames <= tx_frames + 32'h0000_0001;
      end
      if (d_last_acc) begin
        rx_frames <= rx_frames + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence ctl_packet_done;
    ctl_accept;
  endsequence

  sequence data_packet_done;
    txd_end;
  endsequence

  data_gate_a: assert property (
    txd_tready |-> tx_state == ESCIF_TX_DATA)
    else $error("data ready while no control packet held");

  ctl_hold_a: assert property (
    ctl_packet_done |=> !txc_tready && tx_state == ESCIF_TX_DATA)
    else $error("control ready not dropped after control packet");

  ctl_reopen_a: assert property (
    data_packet_done |=> txc_tready && !txd_tready)
    else $error("control ready not restored after data packet");

  ready_edge_a: assert property (
    $changed(txd_tready) || $changed(txc_tready) |-> $past(sedge))
    else $error("ready changed away from a stream clock edge");

  loop_nocsum_a: assert property (
    ctl_accept && flag_rxstat |=> tx_info.loopback && !tx_info.csum_on)
    else $error("checksum enabled on receive-status frame");

  udp_ones_a: assert property (
    clk_en && tx_frame_is_udp && csum_zero |=>
    tx_csum_final == ESCIF_CSUM_ONES)
    else $error("zero udp checksum not replaced by all ones");

  stat_flag_a: assert property (
    load_s && rxs_first |=> rxs.tdata[31:28] == ESCIF_FLAG_RXSTAT)
    else $error("first status word lacks status flag");

  stat_first_a: assert property (
    rxd.tvalid |-> rx_state == ESCIF_RX_DATA && !rxs.tvalid)
    else $error("receive data offered before status completed");

  full_beat_a: assert property (
    (rxd.tvalid && !rxd.tlast) || (mac_tx.tvalid && !mac_tx.tlast) |->
    rxd.tvalid && !rxd.tlast ? rxd.tstrb == ESCIF_STRB_FULL :
    mac_tx.tstrb == ESCIF_STRB_FULL)
    else $error("non-final beat with partial strobes");

  build_wr_a: assert property (
    wr_ctrl |=> csum_build == $past(hwdata[ESCIF_CTRL_BUILD_BIT]))
    else $error("build option write not stored");

endmodule : escif_core
`default_nettype wire

// ### tb/escif_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module escif_src_model
  import escif_pkg::*;
(
  // Stream clock, reset and throttle request.
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic slow,
  // Transmit streams towards the device.
  output escif_axis_t txc,
  input wire logic txc_tready,
  output escif_axis_t txd,
  input wire logic txd_tready,
  // Receive streams from the device.
  input wire escif_axis_t rxs,
  output logic rxs_ready,
  input wire escif_axis_t rxd,
  output logic rxd_ready
);
  // ------------------------------------------------------------
  // Stream source and sink
  // ------------------------------------------------------------
  escif_axis_t txc_q[$], txd_q[$], rs_q[$], rd_q[$];
  logic ph;

  // A released stream shows the inverse, so a stale beat cannot pass.
  function automatic escif_axis_t idle(escif_axis_t b);
    return {1'b0, ~b.tdata, ~b.tstrb, 1'b0};
  endfunction : idle

  always @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      txc <= '0;
      txd <= '0;
      rxs_ready <= 1'b0;
      rxd_ready <= 1'b0;
      ph <= 1'b0;
    end else begin
      if (txc.tvalid && txc_tready) void'(txc_q.pop_front());
      if (txd.tvalid && txd_tready) void'(txd_q.pop_front());
      if (rxs.tvalid && rxs_ready) rs_q.push_back(rxs);
      if (rxd.tvalid && rxd_ready) rd_q.push_back(rxd);
      ph <= ~ph;
      rxs_ready <= !slow || ph;
      rxd_ready <= !slow || !ph;
      txc <= (txc_q.size() != 0) ? txc_q[0] : idle(txc);
      txd <= (txd_q.size() != 0) ? txd_q[0] : idle(txd);
    end
  end
endmodule : escif_src_model
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import escif_pkg::*;
;
  // ------------------------------------------------------------
  // Bench
  // ------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic sclk = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, txc_tready, txd_tready, rxs_ready, rxd_ready;
  logic [31:0] hrdata;
  logic mac_tx_tready = 1'b1;
  logic udp = 1'b0;
  logic slow = 1'b0;
  logic tgl = 1'b0;
  logic build = 1'b1;
  logic first = 1'b1;
  logic [3:0] flag = 4'h0;
  logic mac_rxs_take, mac_rxd_take;
  logic [15:0] csum_in = 16'h0;
  logic [15:0] seed = 16'h0;
  logic [15:0] ofs = 16'h000e;
  logic [15:0] csum_out;
  escif_axis_t txc, txd, rxs, rxd, mac_tx;
  escif_axis_t mac_rxs = '0;
  escif_axis_t mac_rxd = '0;
  escif_txinfo_t info;
  escif_axis_t ms_q[$], md_q[$], mt_q[$], ex_q[$];
  int n_fail = 0;
  int check_count = 0;
  int n_ctl = 0, n_dat = 0, n_rs = 0, n_rd = 0;

  escif_core uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_status_stream_clock(sclk), .txc(txc), .txc_tready(txc_tready),
    .txd(txd), .txd_tready(txd_tready), .rxs(rxs),
    .rx_status_stream_ready(rxs_ready), .rxd(rxd), .rxd_tready(rxd_ready),
    .mac_tx(mac_tx), .mac_tx_tready(mac_tx_tready), .tx_info(info),
    .tx_csum_result(csum_in), .tx_frame_is_udp(udp),
    .tx_csum_final(csum_out), .mac_rxs(mac_rxs), .mac_rxs_take(mac_rxs_take),
    .mac_rxd(mac_rxd), .mac_rxd_take(mac_rxd_take));

  escif_src_model src (.sclk(sclk), .rst_n(hresetn), .slow(slow),
    .txc(txc), .txc_tready(txc_tready), .txd(txd), .txd_tready(txd_tready),
    .rxs(rxs), .rxs_ready(rxs_ready), .rxd(rxd), .rxd_ready(rxd_ready));

  always #10 hclk = ~hclk;
  initial begin
    #7;
    forever #80 sclk = ~sclk;
  end

  task automatic conclude;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_sz(ref escif_axis_t q[$], input int n);
    int i;
    for (i = 0; i < 20000 && q.size() < n; i++) @(posedge hclk);
    if (i == 20000) begin
      n_fail++;
      conclude();
    end
  endtask : wait_sz

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 64);
    rd = hrdata;
    if (i >= 64) begin
      n_fail++;
      conclude();
    end
  endtask : ahb

  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rreg

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask : wreg

  task automatic ctl(input logic [3:0] fl, input logic [1:0] md);
    logic [31:0] w [6];
    seed = seed + 16'h0111;
    ofs = ofs + 16'h0002;
    w = '{{fl, 28'h0}, {30'h0, md}, {ofs, ofs + 16'h001a},
          {16'hbeef, seed}, 32'hdead0004, 32'hdead0005};
    for (int k = 0; k < 6; k++)
      src.txc_q.push_back({1'b1, w[k], ESCIF_STRB_FULL, k == 5});
  endtask : ctl

  task automatic frame(input logic [3:0] fl, input logic [1:0] md,
                       input int n, input logic [3:0] ls);
    escif_axis_t b;
    logic [1:0] fx;
    ctl(fl, md);
    for (int k = 0; k < n; k++) begin
      b = {1'b1, 24'h5a0000, n[3:0], k[3:0],
           (k == n - 1) ? ls : ESCIF_STRB_FULL, k == n - 1};
      src.txd_q.push_back(b);
      ex_q.push_back(b);
    end
    wait_sz(mt_q, ex_q.size());
    foreach (ex_q[k]) chk(mt_q[k], ex_q[k]);
    mt_q = {};
    ex_q = {};
    fx[1] = fl == ESCIF_FLAG_NORMAL && md == ESCIF_CSUM_PARTIAL && build;
    fx[0] = fl == ESCIF_FLAG_RXSTAT;
    chk({info.csum_on, info.loopback}, fx);
    if (fl == ESCIF_FLAG_NORMAL)
      chk(info[47:0], {ofs, ofs + 16'h001a, seed});
  endtask : frame

  // MAC side: holds offered words until taken, gathers transmit beats.
  always @(posedge hclk) begin
    tgl <= ~tgl;
    mac_tx_tready <= !slow || tgl;
    if (mac_tx.tvalid && mac_tx_tready) mt_q.push_back(mac_tx);
    if (mac_rxs_take) void'(ms_q.pop_front());
    if (mac_rxd_take) void'(md_q.pop_front());
    mac_rxs <= (ms_q.size() != 0) ? ms_q[0] : src.idle(mac_rxs);
    mac_rxd <= (md_q.size() != 0) ? md_q[0] : src.idle(mac_rxd);
  end

  // Order of packets as seen on the stream pins.
  always @(posedge sclk) begin
    if (hresetn && txc.tvalid && txc_tready) begin
      chk(n_ctl, n_dat);
      if (first) flag = txc.tdata[31:28];
      first = txc.tlast;
      if (txc.tlast && (flag == 4'ha || flag == 4'h5)) n_ctl++;
    end
    if (hresetn && txd.tvalid && txd_tready) begin
      chk(n_ctl, n_dat + 1);
      if (txd.tlast) n_dat++;
    end
    if (hresetn && rxs.tvalid && rxs_ready) begin
      chk(n_rs, n_rd);
      if (rxs.tlast) n_rs++;
    end
    if (hresetn && rxd.tvalid && rxd_ready) begin
      chk(n_rs, n_rd + 1);
      if (rxd.tlast) n_rd++;
    end
  end

  initial begin : main
    logic [15:0] ex;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({hreadyout, hresp, txd_tready}, 3'h4);
    rreg(ESCIF_CTRL_OFS, {31'h0, ESCIF_CTRL_BUILD_RST});
    rreg(ESCIF_TXCNT_OFS, ESCIF_CNT_RST);
    rreg(8'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      slow <= i[1];
      frame(ESCIF_FLAG_NORMAL, {1'b0, i[0]}, i + 1,
            {i >= 3, i >= 2, i >= 1, 1'b1});
    end
    rreg(ESCIF_STAT_OFS, 32'h8);
    wreg(ESCIF_CTRL_OFS, 32'h0);
    build = 1'b0;
    frame(ESCIF_FLAG_NORMAL, ESCIF_CSUM_PARTIAL, 2, 4'hf);
    wreg(ESCIF_CTRL_OFS, 32'h1);
    build = 1'b1;
    ctl(4'h3, ESCIF_CSUM_PARTIAL);
    frame(ESCIF_FLAG_NORMAL, ESCIF_CSUM_PARTIAL, 1, 4'h1);
    frame(ESCIF_FLAG_RXSTAT, ESCIF_CSUM_PARTIAL, 3, 4'h7);
    rreg(ESCIF_TXCNT_OFS, 32'h7);
    rreg(ESCIF_STAT_OFS, 32'h2);
    for (int k = 0; k < 3; k++) begin
      csum_in <= (k == 2) ? 16'h1234 : ESCIF_CSUM_ZERO;
      udp <= (k != 1);
      repeat (3) @(posedge hclk);
      ex = (k == 0) ? ESCIF_CSUM_ONES : csum_in;
      chk(csum_out, ex);
    end
    for (int k = 0; k < 6; k++)
      ms_q.push_back({1'b1, 4'h3, 24'h0, k[3:0], 4'hf, k == 5});
    for (int k = 0; k < 3; k++)
      md_q.push_back({1'b1, 28'hd00d000, k[3:0],
                      k == 2 ? 4'h3 : 4'hf, k == 2});
    wait_sz(src.rd_q, 3);
    chk(src.rs_q.size(), 6);
    foreach (src.rs_q[k])
      chk(src.rs_q[k], {1'b1, (k == 0) ? 4'h5 : 4'h3, 24'h0, k[3:0],
                        4'hf, k == 5});
    foreach (src.rd_q[k])
      chk(src.rd_q[k], {1'b1, 28'hd00d000, k[3:0],
                        k == 2 ? 4'h3 : 4'hf, k == 2});
    // The frame count moves a few clocks after the last beat is taken.
    repeat (4) @(posedge hclk);
    rreg(ESCIF_RXCNT_OFS, 32'h1);
    conclude();
  end
endmodule : tb
`default_nettype wire
